// ===== include/acs_pkg.sv
// Package: control word layout, status layout, decode enums, timing.
`default_nettype none
package acs_pkg;
    localparam int CTRL_W = 14;
    localparam int STAT_W = 16;
    // Control word bit positions
    localparam int C_CFG = 13;
    localparam int C_CH_HI = 12;
    localparam int C_CH_LO = 10;
    localparam int C_PM_HI = 9;
    localparam int C_PM_LO = 8;
    localparam int C_RB_HI = 7;
    localparam int C_RB_LO = 6;
    localparam int C_IFM = 5;
    localparam int C_CONV = 4;
    localparam int C_CALTYPE = 3;
    localparam int C_SLOT_HI = 2;
    localparam int C_SLOT_LO = 1;
    localparam int C_LAUNCH = 0;
    // Status bit positions
    localparam int S_ZERO = 15;
    localparam int S_BUSY = 14;
    localparam int S_DONTCARE = 4;
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    localparam logic [1:0] RB_STATUS = 2'h3;
    // Step and conversion durations in ns, counts at 8 ns clock
    localparam int CLK_NS = 8;
    localparam int CONV_NS = 4000;
    localparam int STEP_NS = 8000;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    // Input select codes: 1..8 analog inputs, 0 analog ground
    localparam logic [3:0] SEL_GND = 4'h0;
    typedef enum logic [1:0] {ACS_STEP_DAC, ACS_STEP_GAIN, ACS_STEP_OFS,
                              ACS_STEP_NONE} acs_step_t;
    typedef enum {ACS_IDLE, ACS_CONV, ACS_CAL} acs_state_t;
endpackage : acs_pkg
`default_nettype wire

// ===== design/acs_chan_decode.sv
// Channel select to sample input pair decode.
`timescale 1ns/1ns
`default_nettype none
module acs_chan_decode
    import acs_pkg::*;
(
    input wire logic input_config_select,
    input wire logic [2:0] channel_sel,
    output logic [3:0] pos_sel,
    output logic [3:0] neg_sel
);
    logic [3:0] odd_in;
    logic [3:0] even_in;
    always_comb
    begin
        odd_in = {1'b0, channel_sel[1:0], 1'b0} + 4'h1;
        even_in = {1'b0, channel_sel[1:0], 1'b0} + 4'h2;
        if (input_config_select)
        begin
            pos_sel = channel_sel[2] ? even_in : odd_in;
            neg_sel = SEL_GND;
        end
        else
        begin
            pos_sel = channel_sel[2] ? even_in : odd_in;
            neg_sel = channel_sel[2] ? odd_in : even_in;
        end
    end
endmodule : acs_chan_decode
`default_nettype wire

// ===== design/acs_control_status.sv
// Converter control register, calibration sequencer and status readback.
//
// Contract
// - Pseudo-differential codes pick pairs, swap on bit2
// - Single-ended: negative is ground, odd then even
// - Self code 000: DAC, gain, offset
// - Self 01 gain+offset, 10 offset, 11 gain
// - System code 100: DAC, system gain, offset
// - System 01 gain+offset, 10 offset, 11 gain
// - Status is read-only, selected by readback 11
// - Status clears to zero at reset
// - Status bit 15 always zero
// - Bit 14 busy for conversion or calibration
// - Bits 13..10 show config and channel
// - Bits 9..8 show power management bits
// - Bits 7..6 read one on status
// - Bit 5 interface mode, cleared each read
// - Bit 3 shows calibration type
// - Bit 0 high while calibration runs
// - Bits 2..1 show calibration selection
// - Readback 11 makes reads return status
// - Conversion start self-clears at completion
// - Calibration launch self-clears at finish
`timescale 1ns/1ns
`default_nettype none
module acs_control_status
    import acs_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int STEP_CYCLES = STEP_CYC
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ctrl_wr,
    input wire logic [13:0] ctrl_wdata,
    input wire logic rd_start,
    input wire logic rd_done,
    output logic [15:0] rd_data,
    output logic rd_is_status,
    output logic [3:0] pos_sel,
    output logic [3:0] neg_sel,
    output logic busy,
    output logic cal_active,
    output logic conv_active,
    output logic [1:0] cal_step,
    output logic cal_system
);
    logic [13:0] ctrl_q, ctrl_d;
    logic [15:0] rd_q, rd_d;
    logic rd_is_status_q, rd_is_status_d;
    logic [3:0] pos_q, pos_d, neg_q, neg_d;
    logic [3:0] pos_w, neg_w;
    acs_state_t st_q, st_d;
    acs_step_t step_q, step_d;
    logic [31:0] cnt_q, cnt_d;
    logic [13:0] live;
    logic busy_q, busy_d, cal_q, cal_d, conv_q, conv_d;

    // Next step of a calibration sequence; NONE ends it
    function automatic acs_step_t next_step(input acs_step_t cur,
                                            input logic [1:0] slot);
        acs_step_t r;
        r = ACS_STEP_NONE;
        case (cur)
            ACS_STEP_DAC: r = ACS_STEP_GAIN;
            ACS_STEP_GAIN: r = (slot == 2'h3) ? ACS_STEP_NONE
                                               : ACS_STEP_OFS;
            default: r = ACS_STEP_NONE;
        endcase
        return r;
    endfunction : next_step

    function automatic acs_step_t first_step(input logic [1:0] slot);
        acs_step_t r;
        r = ACS_STEP_DAC;
        case (slot)
            2'h0: r = ACS_STEP_DAC;
            2'h1: r = ACS_STEP_GAIN;
            2'h2: r = ACS_STEP_OFS;
            default: r = ACS_STEP_GAIN;
        endcase
        return r;
    endfunction : first_step

    acs_chan_decode u_dec (
        .input_config_select(ctrl_q[C_CFG]),
        .channel_sel(ctrl_q[C_CH_HI:C_CH_LO]),
        .pos_sel(pos_w),
        .neg_sel(neg_w)
    );

    // Live view: a write in the read-start cycle is already visible
    assign live = ctrl_wr ? ctrl_wdata : ctrl_q;

    always_comb
    begin
        ctrl_d = ctrl_q;
        st_d = st_q;
        step_d = step_q;
        cnt_d = cnt_q;
        if (ctrl_wr)
        begin
            ctrl_d = ctrl_wdata;
        end
        case (st_q)
            ACS_IDLE:
            begin
                if (ctrl_d[C_LAUNCH])
                begin
                    st_d = ACS_CAL;
                    step_d = first_step(ctrl_d[C_SLOT_HI:C_SLOT_LO]);
                    cnt_d = 32'h0;
                end
                else if (ctrl_d[C_CONV])
                begin
                    st_d = ACS_CONV;
                    cnt_d = 32'h0;
                end
            end
            ACS_CONV:
            begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'(CONV_CYCLES - 1))
                begin
                    st_d = ACS_IDLE;
                    ctrl_d[C_CONV] = 1'b0;
                end
            end
            ACS_CAL:
            begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'(STEP_CYCLES - 1))
                begin
                    cnt_d = 32'h0;
                    step_d = next_step(step_q,
                                       ctrl_q[C_SLOT_HI:C_SLOT_LO]);
                    if (step_d == ACS_STEP_NONE)
                    begin
                        st_d = ACS_IDLE;
                        ctrl_d[C_LAUNCH] = 1'b0;
                    end
                end
            end
            default: st_d = ACS_IDLE;
        endcase
        // Interface mode drops after every read cycle
        if (rd_done)
        begin
            ctrl_d[C_IFM] = 1'b0;
        end
        // Registered so the status outputs carry no decode glitches
        busy_d = (st_d != ACS_IDLE);
        cal_d = (st_d == ACS_CAL);
        conv_d = (st_d == ACS_CONV);
    end

    always_comb
    begin
        rd_d = rd_q;
        rd_is_status_d = (live[C_RB_HI:C_RB_LO] == RB_STATUS);
        pos_d = pos_w;
        neg_d = neg_w;
        // Other read targets live outside this block; hold last word
        if (rd_start && rd_is_status_d)
        begin
            rd_d = '0;
            rd_d[S_ZERO] = 1'b0;
            rd_d[S_BUSY] = (st_q != ACS_IDLE);
            rd_d[13:10] = live[C_CFG:C_CH_LO];
            rd_d[9:8] = live[C_PM_HI:C_PM_LO];
            rd_d[7:6] = 2'h3;
            rd_d[5] = live[C_IFM];
            rd_d[S_DONTCARE] = 1'b0;
            rd_d[3] = live[C_CALTYPE];
            rd_d[2:1] = live[C_SLOT_HI:C_SLOT_LO];
            rd_d[0] = (st_q == ACS_CAL);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= CTRL_RESET;
            rd_q <= STAT_RESET;
            rd_is_status_q <= 1'b0;
            pos_q <= 4'h0;
            neg_q <= 4'h0;
            st_q <= ACS_IDLE;
            step_q <= ACS_STEP_NONE;
            cnt_q <= 32'h0;
            busy_q <= 1'b0;
            cal_q <= 1'b0;
            conv_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rd_q <= rd_d;
            rd_is_status_q <= rd_is_status_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            st_q <= st_d;
            step_q <= step_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            cal_q <= cal_d;
            conv_q <= conv_d;
        end
    end

    assign rd_data = rd_q;
    assign rd_is_status = rd_is_status_q;
    assign pos_sel = pos_q;
    assign neg_sel = neg_q;
    assign busy = busy_q;
    assign cal_active = cal_q;
    assign conv_active = conv_q;
    assign cal_step = step_q;
    assign cal_system = ctrl_q[C_CALTYPE];

    property zero_top_p;
        @(posedge core_clk) disable iff (sys_rst) rd_q[S_ZERO] == 1'b0;
    endproperty
    status_zero_bit_a: assert property (zero_top_p)
        else $error("status bit 15 not zero");

    status_marker_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        rd_start && rd_is_status_d |=> rd_q[7:6] == 2'h3)
        else $error("status marker bits wrong");

    status_busy_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        rd_start && rd_is_status_d |=> rd_q[S_BUSY] == $past(busy))
        else $error("busy bit does not match state");

    status_cal_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        rd_start && rd_is_status_d |=> rd_q[0] == $past(cal_active))
        else $error("calibration bit wrong");

    status_chan_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        rd_start && rd_is_status_d |=> rd_q[13:10] == $past(live[13:10]))
        else $error("channel field wrong");

    status_dontcare_a: assert property (@(posedge core_clk)
        disable iff (sys_rst) rd_q[S_DONTCARE] == 1'b0)
        else $error("bit 4 not zero");

    mode_clear_a: assert property (@(posedge core_clk)
        disable iff (sys_rst) rd_done |=> !ctrl_q[C_IFM])
        else $error("interface mode not cleared after read");

    sequence conv_run_s;
        conv_active [*2];
    endsequence
    conv_clear_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        conv_run_s ##1 !conv_active
        |-> !ctrl_q[C_CONV])
        else $error("conversion start not self-cleared");

    cal_clear_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $fell(cal_active) |-> !ctrl_q[C_LAUNCH])
        else $error("calibration launch not self-cleared");

    cal_order_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        cal_active && step_q == ACS_STEP_DAC && step_d != step_q
        |-> step_d == ACS_STEP_GAIN)
        else $error("DAC step not followed by gain");

    sel_gnd_a: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $past(ctrl_q[C_CFG]) |-> neg_q == SEL_GND)
        else $error("single-ended negative not ground");
endmodule : acs_control_status
`default_nettype wire

// ===== sim/acs_host_model.sv
// Host processor model driving the control and read strobes.
`timescale 1ns/1ns
`default_nettype none
module acs_host_model
(
    input wire logic core_clk,
    input wire logic [15:0] rd_data,
    output logic ctrl_wr,
    output logic [13:0] ctrl_wdata,
    output logic rd_start,
    output logic rd_done
);
    initial
    begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 14'h0000;
        rd_start = 1'b0;
        rd_done = 1'b0;
    end
    // Released word shows its inverse, so stale data never looks valid
    task automatic write_ctrl(input logic [13:0] w);
        @(negedge core_clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= w;
        @(negedge core_clk);
        ctrl_wr <= 1'b0;
        ctrl_wdata <= ~w;
    endtask : write_ctrl
    task automatic read_status(output logic [15:0] d);
        @(negedge core_clk);
        rd_start <= 1'b1;
        @(negedge core_clk);
        rd_start <= 1'b0;
        @(negedge core_clk);
        d = rd_data;
        rd_done <= 1'b1;
        @(negedge core_clk);
        rd_done <= 1'b0;
    endtask : read_status
endmodule : acs_host_model
`default_nettype wire

// ===== sim/adc_channel_cal_status_decode_bench.sv
// Self-checking bench for the control, calibration and status block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            $display("unexpected t=%0t got %h exp %h", $time, got, exp); \
            n_mismatch++; \
        end \
    end
module adc_channel_cal_status_decode_bench
    import acs_pkg::*;
();
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ctrl_wr, rd_start, rd_done, rd_is_status;
    logic busy, cal_active, conv_active, cal_system;
    logic [13:0] ctrl_wdata, w;
    logic [15:0] rd_data, d;
    logic [3:0] pos_sel, neg_sel;
    logic [1:0] cal_step;
    logic [7:0] seq;
    logic was_cal;
    logic [31:0] rs;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int i;
    always #4 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic logic [15:0] stat(input logic [13:0] c,
                                         input logic b, input logic cl);
        return {1'b0, b, c[13:8], 2'h3, c[5], 1'b0, c[3], c[2:1], cl};
    endfunction : stat
    // Input number: odd of the pair, plus one when bit 2 swaps it
    function automatic logic [7:0] sel_exp(input logic [3:0] c);
        logic [3:0] b;
        b = {1'b0, c[1:0], 1'b0};
        return {b + 4'h1 + {3'h0, c[2]},
                c[3] ? 4'h0 : b + 4'h2 - {3'h0, c[2]}};
    endfunction : sel_exp
    // Step codes plus one, oldest in the upper bits
    function automatic logic [7:0] steps(input logic [1:0] s);
        case (s)
            2'h0: return 8'h1B;
            2'h1: return 8'h0B;
            2'h2: return 8'h03;
            default: return 8'h02;
        endcase
    endfunction : steps
    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 200)
        begin
            @(negedge core_clk);
            t++;
        end
        repeat (3) @(negedge core_clk);
        `CHK(busy, 1'b0)
    endtask : wait_idle
    acs_control_status #(.CONV_CYCLES(8), .STEP_CYCLES(8))
        acs_control_status_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .rd_start(rd_start),
        .rd_done(rd_done), .rd_data(rd_data), .rd_is_status(rd_is_status),
        .pos_sel(pos_sel), .neg_sel(neg_sel), .busy(busy),
        .cal_active(cal_active), .conv_active(conv_active),
        .cal_step(cal_step), .cal_system(cal_system));
    acs_host_model acs_host_model_inst (.core_clk(core_clk),
        .rd_data(rd_data), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .rd_start(rd_start), .rd_done(rd_done));
    // Step trace restarts on the first cycle of each calibration
    always @(negedge core_clk)
    begin
        if (cal_active === 1'b1 && (was_cal !== 1'b1 ||
            cal_step + 2'h1 !== seq[1:0]))
            seq <= {(was_cal === 1'b1) ? seq[5:0] : 6'h00, cal_step + 2'h1};
        was_cal <= cal_active;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    initial
    begin
        rs = 32'h0000E7A7;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        `CHK(rd_data, STAT_RESET)
        `CHK({busy, cal_active, cal_step}, 4'h3)
        for (i = 0; i < 16; i++)
        begin
            rs = xs(rs);
            w = {i[3:0], rs[9:8], 2'h3, rs[5], 1'b0, rs[3:1], 1'b0};
            acs_host_model_inst.write_ctrl(w);
            @(negedge core_clk);
            `CHK({pos_sel, neg_sel}, sel_exp(w[13:10]))
            acs_host_model_inst.read_status(d);
            `CHK(d, stat(w, 1'b0, 1'b0))
            `CHK(rd_is_status, 1'b1)
            acs_host_model_inst.read_status(d);
            w[5] = 1'b0;
            `CHK(d, stat(w, 1'b0, 1'b0))
        end
        for (i = 0; i < 8; i++)
        begin
            rs = xs(rs);
            w = {rs[13:8], 2'h3, rs[5], 1'b0, i[2:0], 1'b1};
            acs_host_model_inst.write_ctrl(w);
            acs_host_model_inst.read_status(d);
            `CHK(d, stat(w, 1'b1, 1'b1))
            `CHK(cal_system, w[3])
            wait_idle();
            `CHK(seq, steps(w[2:1]))
        end
        rs = xs(rs);
        w = {rs[13:8], 2'h3, 2'h3, 4'h0};
        acs_host_model_inst.write_ctrl(w);
        acs_host_model_inst.read_status(d);
        `CHK(d, stat(w, 1'b1, 1'b0))
        `CHK({conv_active, cal_active}, 2'h2)
        wait_idle();
        acs_host_model_inst.read_status(d);
        w[5] = 1'b0;
        `CHK(d, stat(w, 1'b0, 1'b0))
        // Other readback target: status word must not be recaptured
        w[7:4] = 4'h0;
        acs_host_model_inst.write_ctrl(w);
        acs_host_model_inst.read_status(d);
        `CHK(rd_is_status, 1'b0)
        `CHK(d, stat(w, 1'b0, 1'b0))
        close_out();
    end
endmodule : adc_channel_cal_status_decode_bench
`undef CHK
`default_nettype wire
